// ### logic/fcsc_pkg.sv
package fcsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Address map
   localparam logic [31:0] FCSC_CMD_AREA  = 32'h007E_0000;
   localparam logic [31:0] FCSC_REG_BASE  = 32'h007F_0000;
   localparam logic [31:0] FCSC_DF_LO     = 32'h0010_0000;
   localparam logic [31:0] FCSC_DF_HI     = 32'h0010_3FFF;
   localparam logic [31:0] FCSC_CF_LO     = 32'hFFF8_0000;
   localparam logic [31:0] FCSC_B1_HI     = 32'hFFFB_FFFF;
   localparam logic [31:0] FCSC_B2_LO     = 32'hFFFC_0000;
   localparam int          FCSC_BANK_BIT  = 18;
   localparam int          FCSC_BLK_SHIFT = 14;
   localparam logic [4:0]  FCSC_TM_BLK_A  = 5'h08;
   localparam logic [4:0]  FCSC_TM_BLK_B  = 5'h09;
   localparam logic [4:0]  FCSC_TM_BLK_C  = 5'h1E;
   localparam logic [4:0]  FCSC_TM_BLK_D  = 5'h1F;
   localparam logic [2:0]  FCSC_HSIZE_W   = 3'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] FCSC_OFF_STATUS = 8'h00;
   localparam logic [7:0] FCSC_OFF_PE_EN  = 8'h04;
   localparam logic [7:0] FCSC_OFF_SADDR  = 8'h08;
   localparam logic [7:0] FCSC_OFF_AVSTAT = 8'h0C;
   localparam logic [7:0] FCSC_OFF_AVIE   = 8'h10;
   localparam logic [7:0] FCSC_OFF_CFG    = 8'h14;
   localparam logic [7:0] FCSC_OFF_UID0   = 8'h18;
   localparam logic [7:0] FCSC_OFF_UID1   = 8'h1C;
   localparam logic [7:0] FCSC_OFF_UID2   = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Fields
   localparam int FCSC_B_RDY    = 15;
   localparam int FCSC_B_ILG    = 14;
   localparam int FCSC_B_ERASE_ERROR_FLAG = 13;
   localparam int FCSC_B_PROGRAM_ERROR_FLAG = 12;
   localparam int FCSC_B_SUSPEND_READY_FLAG = 11;
   localparam int FCSC_B_ERASE_SUSPENDED_FLAG = 9;
   localparam int FCSC_B_PROGRAM_SUSPENDED_FLAG = 8;
   localparam int FCSC_AV_CF    = 0;
   localparam int FCSC_AV_DF    = 1;
   localparam int FCSC_CFG_DUAL = 0;
   localparam int FCSC_CFG_TRUST = 1;
   localparam logic [1:0] FCSC_PE_RST = 2'h2;
   localparam logic [1:0] FCSC_PE_ON  = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Commands and operation kinds
   localparam logic [7:0] FCSC_CMD_PROG    = 8'h01;
   localparam logic [7:0] FCSC_CMD_ERASE   = 8'h02;
   localparam logic [7:0] FCSC_CMD_BLANK   = 8'h03;
   localparam logic [7:0] FCSC_CMD_SUSPEND = 8'h04;
   localparam logic [7:0] FCSC_CMD_RESUME  = 8'h05;
   localparam logic [7:0] FCSC_CMD_STOP    = 8'h06;
   localparam logic [1:0] FCSC_KIND_PROG   = 2'h0;
   localparam logic [1:0] FCSC_KIND_ERASE  = 2'h1;
   localparam logic [1:0] FCSC_KIND_BLANK  = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing counts
   localparam int FCSC_DF_RD_FCLK = 8;
   localparam int FCSC_FCLK_DIV   = 2;
   localparam int FCSC_OP_CYC     = 64;
   localparam int FCSC_SUS_CYC    = 4;

   typedef enum logic [5:0] {
      FCSC_ST_IDLE  = 6'b000001,
      FCSC_ST_BUSY  = 6'b000010,
      FCSC_ST_SUSPG = 6'b000100,
      FCSC_ST_SUSP  = 6'b001000,
      FCSC_ST_RESG  = 6'b010000,
      FCSC_ST_STOPG = 6'b100000
   } fcsc_state_t;

endpackage : fcsc_pkg

// ### logic/fcsc_flash_reader.sv
`timescale 1ns/1ps
module fcsc_flash_reader
   import fcsc_pkg::*;
#(
   parameter int DF_FCLK = FCSC_DF_RD_FCLK
)(
   // Clock and reset
   input  logic        hclk,
   input  logic        hresetn,
   // Request
   input  logic        start,
   input  logic        is_df,
   input  logic        fclk_en,
   // Array data
   input  logic [31:0] rdata,
   // Answer
   output logic        done_r,
   output logic [31:0] data_r
);
   localparam int CW = $clog2(DF_FCLK + 1);

   logic          act_r;
   logic          df_r;
   logic [CW-1:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_r  <= 1'b0;
         df_r   <= 1'b0;
         cnt_r  <= '0;
         done_r <= 1'b0;
         data_r <= 32'h0000_0000;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            act_r <= 1'b1;
            df_r  <= is_df;
            cnt_r <= '0;
         end else if (act_r) begin
            if (!df_r || (fclk_en && cnt_r == CW'(DF_FCLK - 1))) begin
               act_r  <= 1'b0;
               done_r <= 1'b1;
               data_r <= rdata;
            end else if (fclk_en) begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end

   AST_DF_RD_MIN: assert property (@(posedge hclk) disable iff (!hresetn)
      start && is_df |=> !done_r [*7])
      else $error("Data flash read finished in under eight flash clocks");

endmodule : fcsc_flash_reader

// ### logic/fcsc_top.sv
`timescale 1ns/1ps
module fcsc_top
   import fcsc_pkg::*;
#(
   parameter int          OP_CYCLES  = FCSC_OP_CYC,
   parameter int          SUS_CYCLES = FCSC_SUS_CYC,
   parameter int          FCLK_DIV   = FCSC_FCLK_DIV,
   // Arbitrary identifier values
   parameter logic [31:0] UID0       = 32'h1111_2222,
   parameter logic [31:0] UID1       = 32'h3333_4444,
   parameter logic [31:0] UID2       = 32'h5555_6666
)(
   // Clock and reset
   input  logic        hclk,
   input  logic        hresetn,
   // AHB-Lite slave
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic        hreadyout,
   output logic        hresp,
   output logic [31:0] hrdata,
   // Flash array
   input  logic [31:0] fl_rdata,
   input  logic        fl_pe_fail,
   output logic [31:0] fl_addr,
   output logic        fl_bank,
   output logic        fl_pe_run,
   output logic [1:0]  fl_pe_kind,
   output logic        fl_pe_df,
   // Interrupt
   output logic        flash_access_error_irq
);
   localparam int OPW = $clog2(OP_CYCLES + 1);
   localparam int SUW = $clog2(SUS_CYCLES + 1);
   localparam int DVW = $clog2(FCLK_DIV + 1);

   fcsc_state_t    state_r;
   logic [1:0]     kind_r;
   logic           tgt_df_r;
   logic [OPW-1:0] op_cnt_r;
   logic [SUW-1:0] aux_cnt_r;
   logic [DVW-1:0] div_r;
   logic           fclk_en_r;
   logic [1:0]     pe_en_r;
   logic [31:0]    sa_r;
   logic [1:0]     av_r;
   logic [1:0]     ie_r;
   logic [1:0]     cfg_r;
   logic           program_suspended_flag_r, erase_suspended_flag_r, program_error_flag_r, erase_error_flag_r, ilg_r;
   logic           dp_reg_r, dp_cmd_r;
   logic [7:0]     dp_off_r;
   logic           hreadyout_r, hresp_r, irq_r;
   logic [31:0]    hrdata_r, fl_addr_r, reg_rd;
   logic           fl_bank_r, fl_pe_run_r, fl_pe_df_r;
   logic [1:0]     fl_pe_kind_r;
   logic           rd_done;
   logic [31:0]    rd_data;
   logic [15:0]    status;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////////
   // Status and command decode
   logic rdy, suspend_ready_flag, aux_done, op_done;
   logic [7:0] cmd;
   logic cmd_wr, is_pe_cmd, cmd_start, cmd_susp, cmd_res, cmd_stop, cmd_bad;

   assign rdy      = (state_r == FCSC_ST_IDLE) || (state_r == FCSC_ST_SUSP);
   assign suspend_ready_flag   = (state_r == FCSC_ST_BUSY) && (kind_r != FCSC_KIND_BLANK);
   assign aux_done = aux_cnt_r == SUW'(SUS_CYCLES - 1);
   assign op_done  = (state_r == FCSC_ST_BUSY) && (op_cnt_r == OPW'(OP_CYCLES - 1));

   always_comb begin
      status                = 16'h0000;
      status[FCSC_B_RDY]    = rdy;
      status[FCSC_B_ILG]    = ilg_r;
      status[FCSC_B_ERASE_ERROR_FLAG] = erase_error_flag_r;
      status[FCSC_B_PROGRAM_ERROR_FLAG] = program_error_flag_r;
      status[FCSC_B_SUSPEND_READY_FLAG] = suspend_ready_flag;
      status[FCSC_B_ERASE_SUSPENDED_FLAG] = erase_suspended_flag_r;
      status[FCSC_B_PROGRAM_SUSPENDED_FLAG] = program_suspended_flag_r;
   end

   assign cmd       = hwdata[7:0];
   assign cmd_wr    = dp_cmd_r;
   assign is_pe_cmd = (cmd == FCSC_CMD_PROG) || (cmd == FCSC_CMD_ERASE) ||
                      (cmd == FCSC_CMD_BLANK);
   assign cmd_start = cmd_wr && is_pe_cmd && (state_r == FCSC_ST_IDLE) &&
                      (pe_en_r == FCSC_PE_ON);
   assign cmd_susp  = cmd_wr && (cmd == FCSC_CMD_SUSPEND) && suspend_ready_flag;
   assign cmd_res   = cmd_wr && (cmd == FCSC_CMD_RESUME) && (state_r == FCSC_ST_SUSP);
   assign cmd_stop  = cmd_wr && (cmd == FCSC_CMD_STOP);
   assign cmd_bad   = cmd_wr && !(cmd_start || cmd_susp || cmd_res || cmd_stop);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= FCSC_ST_IDLE;
      end else begin
         unique case (state_r)
            FCSC_ST_IDLE: begin
               if (cmd_stop) state_r <= FCSC_ST_STOPG;
               else if (cmd_start) state_r <= FCSC_ST_BUSY;
            end
            FCSC_ST_BUSY: begin
               if (cmd_stop) state_r <= FCSC_ST_STOPG;
               else if (cmd_susp) state_r <= FCSC_ST_SUSPG;
               else if (op_done) state_r <= FCSC_ST_IDLE;
            end
            FCSC_ST_SUSPG: begin
               if (aux_done) state_r <= FCSC_ST_SUSP;
            end
            FCSC_ST_SUSP: begin
               if (cmd_stop) state_r <= FCSC_ST_STOPG;
               else if (cmd_res) state_r <= FCSC_ST_RESG;
            end
            FCSC_ST_RESG: begin
               if (aux_done) state_r <= FCSC_ST_BUSY;
            end
            FCSC_ST_STOPG: begin
               if (aux_done) state_r <= FCSC_ST_IDLE;
            end
            default: state_r <= FCSC_ST_IDLE;
         endcase
      end
   end

   // Remaining operation time survives a suspend
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_cnt_r  <= '0;
         aux_cnt_r <= '0;
         kind_r    <= FCSC_KIND_PROG;
         tgt_df_r  <= 1'b0;
      end else begin
         if (cmd_start) begin
            op_cnt_r <= '0;
            kind_r   <= cmd[1:0] - 2'h1;
            tgt_df_r <= (sa_r >= FCSC_DF_LO) && (sa_r <= FCSC_DF_HI);
         end else if (state_r == FCSC_ST_BUSY && !cmd_susp && !cmd_stop) begin
            op_cnt_r <= op_cnt_r + 1'b1;
         end
         if (state_r == FCSC_ST_SUSPG || state_r == FCSC_ST_RESG ||
             state_r == FCSC_ST_STOPG) begin
            aux_cnt_r <= aux_done ? '0 : aux_cnt_r + 1'b1;
         end else begin
            aux_cnt_r <= '0;
         end
      end
   end

   // Error sets win over the forced-stop clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         program_suspended_flag_r <= 1'b0;
         erase_suspended_flag_r <= 1'b0;
         program_error_flag_r <= 1'b0;
         erase_error_flag_r <= 1'b0;
         ilg_r    <= 1'b0;
      end else begin
         if (state_r == FCSC_ST_SUSPG && aux_done) begin
            program_suspended_flag_r <= kind_r == FCSC_KIND_PROG;
            erase_suspended_flag_r <= kind_r == FCSC_KIND_ERASE;
         end else if (cmd_stop || (state_r == FCSC_ST_RESG && aux_done)) begin
            program_suspended_flag_r <= 1'b0;
            erase_suspended_flag_r <= 1'b0;
         end
         if (op_done && fl_pe_fail && kind_r == FCSC_KIND_PROG) program_error_flag_r <= 1'b1;
         else if (cmd_stop) program_error_flag_r <= 1'b0;
         if (op_done && fl_pe_fail && kind_r != FCSC_KIND_PROG) erase_error_flag_r <= 1'b1;
         else if (cmd_stop) erase_error_flag_r <= 1'b0;
         if (cmd_bad) ilg_r <= 1'b1;
         else if (cmd_stop) ilg_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash clock enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r     <= '0;
         fclk_en_r <= 1'b0;
      end else begin
         fclk_en_r <= div_r == DVW'(FCLK_DIV - 1);
         div_r     <= (div_r == DVW'(FCLK_DIV - 1)) ? '0 : div_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address phase decode
   logic ap, in_reg, in_cmd, in_df, in_cf, df_busy, tm_hit, rd_start, wr_ok;
   logic [4:0] blk;

   assign ap      = hsel && hready && htrans[1];
   assign wr_ok   = ap && hwrite && (hsize == FCSC_HSIZE_W);
   assign in_reg  = haddr[31:8] == FCSC_REG_BASE[31:8];
   assign in_cmd  = haddr[31:16] == FCSC_CMD_AREA[31:16];
   assign in_df   = (haddr >= FCSC_DF_LO) && (haddr <= FCSC_DF_HI);
   assign in_cf   = haddr >= FCSC_CF_LO;
   assign blk     = haddr[FCSC_BLK_SHIFT +: 5];
   assign df_busy = tgt_df_r && !rdy;
   assign tm_hit  = in_cf && !cfg_r[FCSC_CFG_TRUST] &&
                    (blk == FCSC_TM_BLK_A || blk == FCSC_TM_BLK_B ||
                     (cfg_r[FCSC_CFG_DUAL] &&
                      (blk == FCSC_TM_BLK_C || blk == FCSC_TM_BLK_D)));
   assign rd_start = ap && !hwrite && ((in_df && !df_busy) || (in_cf && !tm_hit));

   always_comb begin
      unique case (haddr[7:0])
         FCSC_OFF_STATUS: reg_rd = {16'h0000, status};
         FCSC_OFF_PE_EN:  reg_rd = {30'h0000_0000, pe_en_r};
         FCSC_OFF_SADDR:  reg_rd = sa_r;
         FCSC_OFF_AVSTAT: reg_rd = {30'h0000_0000, av_r};
         FCSC_OFF_AVIE:   reg_rd = {30'h0000_0000, ie_r};
         FCSC_OFF_CFG:    reg_rd = {30'h0000_0000, cfg_r};
         FCSC_OFF_UID0:   reg_rd = UID0;
         FCSC_OFF_UID1:   reg_rd = UID1;
         FCSC_OFF_UID2:   reg_rd = UID2;
         default:         reg_rd = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus phases and read return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_reg_r    <= 1'b0;
         dp_cmd_r    <= 1'b0;
         dp_off_r    <= 8'h00;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
         hrdata_r    <= 32'h0000_0000;
         fl_addr_r   <= 32'h0000_0000;
         fl_bank_r   <= 1'b0;
      end else begin
         dp_reg_r <= wr_ok && in_reg;
         dp_cmd_r <= wr_ok && in_cmd;
         if (ap) dp_off_r <= haddr[7:0];
         if (rd_start) begin
            hreadyout_r <= 1'b0;
            fl_addr_r   <= haddr;
            fl_bank_r   <= haddr[FCSC_BANK_BIT];
         end else if (rd_done) begin
            hreadyout_r <= 1'b1;
            hrdata_r    <= rd_data;
         end else if (ap && !hwrite) begin
            hrdata_r <= in_reg ? reg_rd : 32'h0000_0000;
         end
      end
   end

   fcsc_flash_reader #(
      .DF_FCLK (FCSC_DF_RD_FCLK)
   ) u_reader (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (rd_start),
      .is_df   (in_df),
      .fclk_en (fclk_en_r),
      .rdata   (fl_rdata),
      .done_r  (rd_done),
      .data_r  (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pe_en_r <= FCSC_PE_RST;
         sa_r    <= 32'h0000_0000;
         ie_r    <= 2'h0;
         cfg_r   <= 2'h0;
      end else if (dp_reg_r) begin
         if (dp_off_r == FCSC_OFF_PE_EN) pe_en_r <= hwdata[1:0];
         if (dp_off_r == FCSC_OFF_SADDR) sa_r <= hwdata;
         if (dp_off_r == FCSC_OFF_AVIE) ie_r <= hwdata[1:0];
         if (dp_off_r == FCSC_OFF_CFG) cfg_r <= hwdata[1:0];
      end
   end

   // Violation flags: write one to clear, a new violation wins
   logic [1:0] av_set, av_clr;
   assign av_set[FCSC_AV_DF] = ap && !hwrite && in_df && df_busy;
   assign av_set[FCSC_AV_CF] = ap && !hwrite && tm_hit;
   assign av_clr = (dp_reg_r && dp_off_r == FCSC_OFF_AVSTAT) ? hwdata[1:0] : 2'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         av_r <= 2'h0;
      end else begin
         av_r <= (av_r & ~av_clr) | av_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_r        <= 1'b0;
         fl_pe_run_r  <= 1'b0;
         fl_pe_kind_r <= FCSC_KIND_PROG;
         fl_pe_df_r   <= 1'b0;
      end else begin
         irq_r        <= |(av_r & ie_r);
         fl_pe_run_r  <= state_r == FCSC_ST_BUSY;
         fl_pe_kind_r <= kind_r;
         fl_pe_df_r   <= tgt_df_r;
      end
   end

   assign hreadyout              = hreadyout_r;
   assign hresp                  = hresp_r;
   assign hrdata                 = hrdata_r;
   assign fl_addr                = fl_addr_r;
   assign fl_bank                = fl_bank_r;
   assign fl_pe_run              = fl_pe_run_r;
   assign fl_pe_kind             = fl_pe_kind_r;
   assign fl_pe_df               = fl_pe_df_r;
   assign flash_access_error_irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // ready drop check
   AST_RDY_DROP: assert property (cmd_start |=> !status[FCSC_B_RDY] [*2])
      else $error("Ready stayed high after a command start");
   AST_PRG_SUSP: assert property (state_r == FCSC_ST_SUSPG && aux_done &&
      kind_r == FCSC_KIND_PROG |=> status[FCSC_B_PROGRAM_SUSPENDED_FLAG] && status[FCSC_B_RDY])
      else $error("Program suspend flag missing after suspend");
   AST_ERS_SUSP: assert property (state_r == FCSC_ST_SUSPG && aux_done &&
      kind_r == FCSC_KIND_ERASE |=> status[FCSC_B_ERASE_SUSPENDED_FLAG] && !status[FCSC_B_PROGRAM_SUSPENDED_FLAG])
      else $error("Erase suspend flag missing after suspend");
   AST_SUS_ACK: assert property (cmd_wr && cmd == FCSC_CMD_SUSPEND &&
      status[FCSC_B_SUSPEND_READY_FLAG] |=> !status[FCSC_B_SUSPEND_READY_FLAG] && !status[FCSC_B_RDY])
      else $error("Suspend request not taken while suspend ready");
   AST_PRG_ERR: assert property (op_done && fl_pe_fail &&
      kind_r == FCSC_KIND_PROG |=> status[FCSC_B_PROGRAM_ERROR_FLAG] && status[FCSC_B_RDY])
      else $error("Program failure not flagged");
   AST_ERS_ERR: assert property (op_done && fl_pe_fail &&
      kind_r == FCSC_KIND_ERASE |=> status[FCSC_B_ERASE_ERROR_FLAG])
      else $error("Erase failure not flagged");
   AST_PE_GATE: assert property (cmd_wr && is_pe_cmd && pe_en_r != FCSC_PE_ON
      |=> state_r != FCSC_ST_BUSY ##1 !fl_pe_run)
      else $error("Operation started with enable field not 01");
   AST_CF_IRQ: assert property (av_r[FCSC_AV_CF] && ie_r[FCSC_AV_CF]
      |=> flash_access_error_irq)
      else $error("Code violation interrupt not raised");
   AST_BGO_RD: assert property (ap && !hwrite && in_df &&
      state_r == FCSC_ST_BUSY && !tgt_df_r |=> !hreadyout && !av_r[FCSC_AV_DF])
      else $error("Data flash read refused during code operation");
   AST_TM_BLK: assert property (ap && !hwrite && tm_hit
      |=> av_r[FCSC_AV_CF] && hreadyout && hrdata == 32'h0000_0000)
      else $error("Protected block read was not refused");
   AST_BUSY_CMD: assert property (cmd_wr && is_pe_cmd && !rdy
      |=> status[FCSC_B_ILG] && $stable(kind_r))
      else $error("Command accepted while busy");

   COV_PROG_DONE: cover property (cmd_start ##[1:300] op_done);
   COV_SUSPEND:   cover property (cmd_susp ##[1:20] state_r == FCSC_ST_SUSP);
   COV_DF_READ:   cover property (rd_start && in_df ##[1:100] rd_done);

endmodule : fcsc_top

// ### dv/test_flash_command_status_control.sv
`timescale 1ns/1ps
module test_flash_command_status_control;
   import fcsc_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] fl_rdata = 32'h0;
   logic        fl_pe_fail = 1'b0;
   logic        hreadyout, hresp, fl_bank, fl_pe_run, fl_pe_df, irq;
   logic [31:0] hrdata, fl_addr, rv;
   logic [1:0]  fl_pe_kind;
   logic [31:0] uid [3] = '{32'h1357_9BDF, 32'h2468_ACE0, 32'h0F1E_2D3C};
   int          bad_count = 0;
   int          comparisons = 0;
   always #4 hclk = ~hclk;
   // Arbitrary identifier values, short counts for a brief run
   fcsc_top #(.OP_CYCLES(8), .SUS_CYCLES(2),
      .UID0(32'h1357_9BDF), .UID1(32'h2468_ACE0), .UID2(32'h0F1E_2D3C)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_rdata(fl_rdata),
      .fl_pe_fail(fl_pe_fail), .fl_addr(fl_addr), .fl_bank(fl_bank), .fl_pe_run(fl_pe_run),
      .fl_pe_kind(fl_pe_kind), .fl_pe_df(fl_pe_df), .flash_access_error_irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Ready sampled at negedge, so the registered value is settled
   task automatic wait_rdy();
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 200) begin
         @(negedge hclk);
         n++;
      end
      if (n >= 200) chk("hreadyout", 32'h1, {31'h0, hreadyout});
   endtask : wait_rdy
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= FCSC_HSIZE_W;
      wait_rdy();
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rv = hrdata;
      @(posedge hclk);
   endtask : xfer
   task automatic rg(input logic [7:0] o, input logic w, input logic [31:0] d);
      xfer(w, FCSC_REG_BASE + {24'h0, o}, d);
   endtask : rg
   task automatic cmd(input logic [7:0] c);
      xfer(1'b1, FCSC_CMD_AREA, {24'h0, c});
   endtask : cmd
   // Polls status until the sequencer reports ready
   task automatic settle();
      int n;
      n = 0;
      do begin
         rg(FCSC_OFF_STATUS, 1'b0, 32'h0);
         n++;
      end while (rv[15] !== 1'b1 && n < 50);
   endtask : settle
   task automatic complete_run();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
   initial begin
      logic [15:0] em;
      void'($urandom(32'h0F946BBB));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rg(FCSC_OFF_STATUS, 1'b0, 32'h0);
      chk("status", 32'h8000, rv);
      rg(FCSC_OFF_PE_EN, 1'b0, 32'h0);
      chk("pe_enable", 32'h2, rv);
      for (int i = 0; i < 3; i++) begin
         rg(FCSC_OFF_UID0 + 8'(4 * i), 1'b0, 32'h0);
         chk("unique_id", uid[i], rv);
      end
      rg(8'h40, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rv);
      $display("test reset values done");
      for (int k = 1; k <= 3; k++) begin
         cmd(8'(k));
         rg(FCSC_OFF_STATUS, 1'b0, 32'h0);
         chk("status_refused", 32'hC000, rv);
         cmd(FCSC_CMD_STOP);
         settle();
         chk("status_stop", 32'h8000, rv);
      end
      $display("test enable refusal done");
      rg(FCSC_OFF_PE_EN, 1'b1, 32'h1);
      for (int k = 0; k < 3; k++) begin
         cmd(8'(k + 1));
         rg(FCSC_OFF_STATUS, 1'b0, 32'h0);
         chk("busy_flags", k < 2 ? 32'h0800 : 32'h0, rv & 32'h8800);
         chk("op_kind", 32'(k), {30'h0, fl_pe_kind});
         cmd(8'(k + 1));
         em = 16'hC000;
         if (k < 2) begin
            cmd(FCSC_CMD_SUSPEND);
            settle();
            chk("suspended", 32'(em | (k == 0 ? 16'h0100 : 16'h0200)), rv);
            cmd(FCSC_CMD_RESUME);
         end
         fl_pe_fail <= 1'b1;
         settle();
         fl_pe_fail <= 1'b0;
         chk("op_error", 32'(em | (k == 0 ? 16'h1000 : 16'h2000)), rv);
         cmd(FCSC_CMD_STOP);
         settle();
      end
      $display("test operations done");
      fl_rdata <= $urandom;
      rg(FCSC_OFF_SADDR, 1'b1, FCSC_DF_LO + ($urandom % 32'h4000));
      cmd(FCSC_CMD_PROG);
      xfer(1'b0, FCSC_DF_LO, 32'h0);
      chk("df_read_busy", 32'h0, rv);
      chk("pe_run", 32'h1, {31'h0, fl_pe_run});
      chk("pe_df", 32'h1, {31'h0, fl_pe_df});
      chk("hresp", 32'h0, {31'h0, hresp});
      rg(FCSC_OFF_AVSTAT, 1'b0, 32'h0);
      chk("violation", 32'h2, rv);
      rg(FCSC_OFF_AVIE, 1'b1, 32'h2);
      // Interrupt flop lags the enable by one edge
      @(posedge hclk);
      @(negedge hclk);
      chk("irq_data", 32'h1, {31'h0, irq});
      rg(FCSC_OFF_AVSTAT, 1'b1, 32'h3);
      rg(FCSC_OFF_AVIE, 1'b1, 32'h0);
      settle();
      rg(FCSC_OFF_SADDR, 1'b1, 32'h0);
      cmd(FCSC_CMD_ERASE);
      xfer(1'b0, FCSC_DF_HI & 32'hFFFF_FFFC, 32'h0);
      chk("df_read_bgo", fl_rdata, rv);
      chk("bank_low", 32'h0, {31'h0, fl_bank});
      settle();
      $display("test data flash done");
      rg(FCSC_OFF_CFG, 1'b1, 32'h1);
      foreach (uid[i]) begin
         xfer(1'b0, FCSC_CF_LO + ({27'h0, i == 0 ? FCSC_TM_BLK_A : FCSC_TM_BLK_D} << 14), 0);
         chk("protected", 32'h0, rv);
      end
      @(negedge hclk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      rg(FCSC_OFF_AVIE, 1'b1, 32'h1);
      @(posedge hclk);
      @(negedge hclk);
      chk("irq_code", 32'h1, {31'h0, irq});
      rg(FCSC_OFF_CFG, 1'b1, 32'h3);
      xfer(1'b0, FCSC_CF_LO + ({27'h0, FCSC_TM_BLK_D} << 14), 32'h0);
      chk("trusted_read", fl_rdata, rv);
      chk("flash_addr", FCSC_CF_LO + ({27'h0, FCSC_TM_BLK_D} << 14), fl_addr);
      xfer(1'b0, FCSC_B2_LO, 32'h0);
      chk("bank", 32'h1, {31'h0, fl_bank});
      $display("test protection done");
      complete_run();
   end
endmodule : test_flash_command_status_control
